/* File: hw/dam_pkg.sv */
// constants and types shared by the dram address mux and expanded_map_control_boundary
package dam_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          APB_ADDR_W    = 20;
  localparam int          APB_DATA_W    = 32;

  // ----------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [17:0] IDX_EMS_CTRL  = 18'h06872;
  localparam logic [17:0] IDX_BANK_CFG  = 18'h00000;
  localparam logic [17:0] IDX_POINTER   = 18'h00001;
  localparam logic [17:0] IDX_PAGE_DATA = 18'h00002;
  localparam logic [17:0] IDX_STATUS    = 18'h00003;

  // ----------------------------------------------------------------
  // control register layout and reset
  // ----------------------------------------------------------------
  localparam int          CTL_W         = 16;
  localparam int          CTL_INC_BIT   = 15;
  localparam int          CTL_LOC_LSB   = 13;
  localparam int          CTL_EN_LSB    = 10;
  localparam int          CTL_RES_BIT   = 7;
  localparam int          CTL_BND_LSB   = 0;
  localparam int          BND_W         = 7;
  localparam logic [15:0] CTL_KEEP_MASK = 16'hecff;
  localparam logic [15:0] CTL_RST       = 16'h0000;

  // frame enable codes
  localparam logic [1:0]  FME_OFF       = 2'b00;
  localparam logic [1:0]  FME_PROG      = 2'b01;
  localparam logic [1:0]  FME_UPPER     = 2'b10;
  localparam logic [1:0]  FME_ALL       = 2'b11;

  // upper frame block start and step between choices
  localparam logic [19:0] UPPER_BASE0   = 20'hc4000;
  localparam logic [19:0] UPPER_STEP    = 20'h04000;

  // ----------------------------------------------------------------
  // page pointer and page registers
  // ----------------------------------------------------------------
  localparam int          PTR_W         = 6;
  localparam int          PAGE_REGS     = 40;
  localparam logic [5:0]  PTR_LAST      = 6'h27;
  localparam logic [5:0]  PTR_RST       = 6'h00;
  localparam logic [15:0] PAGE_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // bank configuration layout
  // ----------------------------------------------------------------
  localparam int          BANK_CFG_W    = 5;
  localparam int          BANK_DEN_LSB  = 0;
  localparam int          BANK_ILV_LSB  = 2;
  localparam int          BANK_PAGE_BIT = 4;
  localparam logic [4:0]  BANK_CFG_RST  = 5'h00;

  typedef enum logic [1:0] {
    DEN_64K, DEN_256K, DEN_1M, DEN_4M
  } dam_density_e;

  typedef enum logic [1:0] {
    ILV_NONE, ILV_2WAY, ILV_4WAY, ILV_RSVD
  } dam_ilv_e;

endpackage

/* File: hw/dam_mux_if.sv */
// request and result of the dram row/column address multiplexer
`timescale 1ns/100ps
interface dam_mux_if;
  import dam_pkg::*;
  logic [24:0]  cpu_addr;
  dam_density_e density;
  dam_ilv_e     ilv;
  logic         page_mode;
  logic         row_phase;
  logic [10:0]  mux_addr;

  modport ctl (output cpu_addr, density, ilv, page_mode, row_phase,
               input  mux_addr);
  modport mux (input  cpu_addr, density, ilv, page_mode, row_phase,
               output mux_addr);
endinterface

/* File: hw/dam_addr_mux.sv */
// dram row/column address multiplexer, registered output
`timescale 1ns/100ps
module dam_addr_mux
  import dam_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // multiplexer request and result
  dam_mux_if.mux   m
);

  logic [10:0] mux_d;
  logic [10:0] mux_q;
  logic [2:0]  lvl;

  // ----------------------------------------------------------------
  // mapping helpers
  // ----------------------------------------------------------------
  // page row: fixed top bits, low bits swapped cumulatively by level
  function automatic logic [10:0] page_row(input logic [24:0] a,
                                           input logic [2:0]  l);
    logic [10:0] r;
    r = {a[22], a[20], a[18], a[16], a[15], a[14],
         a[13], a[12], a[11], a[10], a[9]};
    if (l >= 3'd1) r[0] = a[17];
    if (l >= 3'd2) r[1] = a[19];
    if (l >= 3'd3) r[2] = a[21];
    if (l >= 3'd4) r[3] = a[23];
    if (l >= 3'd5) r[4] = a[24];
    return r;
  endfunction

  function automatic logic [2:0] ilv_steps(input dam_ilv_e i);
    case (i)
      ILV_2WAY: return 3'd1;
      ILV_4WAY: return 3'd2;
      default:  return 3'd0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // density plus interleave of the bank being accessed picks one socket wiring
  assign lvl = {1'b0, m.density} + ilv_steps(m.ilv);

  // row and column share the same pins, phase chooses
  always_comb begin
    mux_d = m.cpu_addr[11:1];
    if (m.page_mode) begin
      mux_d = m.row_phase ? page_row(m.cpu_addr, lvl)
                          : m.cpu_addr[11:1];
    end else begin
      case (m.ilv)
        ILV_2WAY: begin
          if (m.row_phase) begin
            mux_d = {m.cpu_addr[11:2], m.cpu_addr[13]};
          end else if (m.density == DEN_1M) begin
            mux_d = {m.cpu_addr[22], m.cpu_addr[20], m.cpu_addr[18],
                     m.cpu_addr[16], m.cpu_addr[15], m.cpu_addr[14],
                     m.cpu_addr[21], m.cpu_addr[12], m.cpu_addr[11],
                     m.cpu_addr[19], m.cpu_addr[17]};
          end else begin
            mux_d = page_row(m.cpu_addr, lvl);
          end
        end
        ILV_4WAY: begin
          // no distinct non-page 4-way wiring, reuse the page one
          mux_d = m.row_phase ? page_row(m.cpu_addr, lvl)
                              : m.cpu_addr[11:1];
        end
        default: begin
          mux_d = m.row_phase ? m.cpu_addr[11:1]
                              : page_row(m.cpu_addr, lvl);
        end
      endcase
    end
  end

  // output flop keeps pin glitches away from the dram
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_q <= 11'h000;
    end else begin
      mux_q <= mux_d;
    end
  end

  assign m.mux_addr = mux_q;

endmodule

/* File: hw/dam_ems_ctrl.sv */
// expanded memory control register and its decoded outputs
`timescale 1ns/100ps
module dam_ems_ctrl
  import dam_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register write port
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  // address under test for the reserve boundary
  input  wire logic [24:0] cpu_addr,
  // register contents and decoded state
  output logic      [15:0] ctrl_q,
  output logic      [19:0] upper_frame_base_q,
  output logic             upper_map_en_q,
  output logic             lower_map_en_q,
  output logic             page_prog_en_q,
  output logic             reserve_hit_q
);

  logic [1:0]       upper_frame_base_sel;
  logic [1:0]       frame_map_enable;
  logic             boundary_use_enable;
  logic [BND_W-1:0] reserve_start_field;
  logic             hit_d;

  assign upper_frame_base_sel = ctrl_q[CTL_LOC_LSB +: 2];
  assign frame_map_enable     = ctrl_q[CTL_EN_LSB +: 2];
  assign boundary_use_enable  = ctrl_q[CTL_RES_BIT];
  assign reserve_start_field  = ctrl_q[CTL_BND_LSB +: BND_W];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // unused bits are dropped so they can never steer anything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTL_RST;
    end else if (wr_en) begin
      ctrl_q <= wdata & CTL_KEEP_MASK;
    end
  end

  // ----------------------------------------------------------------
  // decoded frame state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_frame_base_q <= UPPER_BASE0;
      upper_map_en_q     <= 1'b0;
      lower_map_en_q     <= 1'b0;
      page_prog_en_q     <= 1'b0;
    end else begin
      upper_frame_base_q <= UPPER_BASE0 +
        UPPER_STEP * {18'h00000, upper_frame_base_sel};
      upper_map_en_q <= frame_map_enable == FME_UPPER ||
                        frame_map_enable == FME_ALL;
      lower_map_en_q <= frame_map_enable == FME_ALL;
      page_prog_en_q <= frame_map_enable != FME_OFF;
    end
  end

  // field is one granule below the start, so strictly above reserves
  assign hit_d = boundary_use_enable &&
                 cpu_addr[24:17] > {1'b0, reserve_start_field};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserve_hit_q <= 1'b0;
    end else begin
      reserve_hit_q <= hit_d;
    end
  end

endmodule

/* File: hw/dam_top.sv */
// dram address multiplexer and expanded_map_control_boundary with apb register access
`timescale 1ns/100ps

module dam_top
  import dam_pkg::*;
#(
  parameter int NUM_BANKS = 4
)(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  // memory cycle request
  input  wire logic [24:0]           cpu_addr,
  input  wire logic [1:0]            bank_sel,
  input  wire logic                  row_phase,
  // dram address pins
  output logic      [10:0]           dram_mux_addr_out,
  // expanded memory state
  output logic      [19:0]           upper_frame_base,
  output logic                       upper_map_en,
  output logic                       lower_map_en,
  output logic                       page_prog_en,
  output logic                       reserve_hit,
  output logic      [PTR_W-1:0]      page_pointer
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int CFG_W = NUM_BANKS * BANK_CFG_W;

  dam_mux_if mux_bus ();

  logic [APB_DATA_W-1:0] prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [CFG_W-1:0]      bank_cfg_q;
  logic [PTR_W-1:0]      ptr_q;
  logic [15:0]           page_mem [PAGE_REGS];
  logic [15:0]           ctrl_q;
  logic                  setup;
  logic                  access;
  logic                  wr_acc;
  logic                  page_acc;
  logic                  ptr_ok;
  logic [17:0]           idx;
  logic                  mapped;
  logic [APB_DATA_W-1:0] rd_d;
  logic [BANK_CFG_W-1:0] cur_cfg;

  // word index from byte address, decode used by mapped, page_acc and every write enable
  function automatic logic is_reg(input logic [APB_ADDR_W-1:0] a,
                                  input logic [17:0]           i);
    return a[1:0] == 2'b00 && a[APB_ADDR_W-1:2] == i;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup    = psel && !penable;
  assign access   = psel && penable && pready_q;
  assign wr_acc   = access && pwrite && !pslverr_q;
  assign idx      = paddr[APB_ADDR_W-1:2];
  assign page_acc = access && !pslverr_q && is_reg(paddr, IDX_PAGE_DATA);
  assign ptr_ok   = ptr_q <= PTR_LAST;
  assign mapped   = is_reg(paddr, IDX_EMS_CTRL) ||
                    is_reg(paddr, IDX_BANK_CFG) ||
                    is_reg(paddr, IDX_POINTER)  ||
                    is_reg(paddr, IDX_PAGE_DATA) ||
                    is_reg(paddr, IDX_STATUS);

  // read mux, sampled during setup so data is ready in access phase
  always_comb begin
    rd_d = '0;
    case (idx)
      IDX_EMS_CTRL:  rd_d = {16'h0000, ctrl_q};
      IDX_BANK_CFG:  rd_d = {{(APB_DATA_W-CFG_W){1'b0}}, bank_cfg_q};
      IDX_POINTER:   rd_d = {{(APB_DATA_W-PTR_W){1'b0}}, ptr_q};
      IDX_PAGE_DATA: rd_d = ptr_ok ? {16'h0000, page_mem[ptr_q]} : '0;
      IDX_STATUS:    rd_d = {28'h0000000, reserve_hit, page_prog_en,
                             lower_map_en, upper_map_en};
      default:       rd_d = '0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_d = '0;
    end
  end

  // one wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped;
        prdata_q  <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // bank configuration
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_cfg_q <= {NUM_BANKS{BANK_CFG_RST}};
    end else if (wr_acc && is_reg(paddr, IDX_BANK_CFG)) begin
      bank_cfg_q <= pwdata[CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // page pointer
  // ----------------------------------------------------------------
  // wraps after the last register so software can sweep all forty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= PTR_RST;
    end else if (wr_acc && is_reg(paddr, IDX_POINTER)) begin
      ptr_q <= pwdata[PTR_W-1:0];
    end else if (page_acc && ctrl_q[CTL_INC_BIT]) begin
      ptr_q <= (ptr_q >= PTR_LAST) ? PTR_RST
                                   : ptr_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // page registers
  // ----------------------------------------------------------------
  // writes dropped while programming is disabled; out-of-range ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PAGE_REGS; i++) begin
        page_mem[i] <= PAGE_RST;
      end
    end else if (page_acc && pwrite && page_prog_en && ptr_ok) begin
      page_mem[ptr_q] <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // expanded_map_control_boundary register
  // ----------------------------------------------------------------
  dam_ems_ctrl dam_ems_ctrl_i (
    .pclk               (pclk),
    .presetn            (presetn),
    .wr_en              (wr_acc && is_reg(paddr, IDX_EMS_CTRL)),
    .wdata              (pwdata[15:0]),
    .cpu_addr           (cpu_addr),
    .ctrl_q             (ctrl_q),
    .upper_frame_base_q (upper_frame_base),
    .upper_map_en_q     (upper_map_en),
    .lower_map_en_q     (lower_map_en),
    .page_prog_en_q     (page_prog_en),
    .reserve_hit_q      (reserve_hit)
  );

  // ----------------------------------------------------------------
  // address multiplexer
  // ----------------------------------------------------------------
  // the selected bank's own settings steer the wiring
  assign cur_cfg = bank_cfg_q[bank_sel*BANK_CFG_W +: BANK_CFG_W];

  assign mux_bus.cpu_addr  = cpu_addr;
  assign mux_bus.density   = dam_density_e'(cur_cfg[BANK_DEN_LSB +: 2]);
  assign mux_bus.ilv       = dam_ilv_e'(cur_cfg[BANK_ILV_LSB +: 2]);
  assign mux_bus.page_mode = cur_cfg[BANK_PAGE_BIT];
  assign mux_bus.row_phase = row_phase;

  dam_addr_mux dam_addr_mux_i (
    .pclk    (pclk),
    .presetn (presetn),
    .m       (mux_bus.mux)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dram_mux_addr_out = mux_bus.mux_addr;
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign page_pointer      = ptr_q;

endmodule

/* File: bench/dam_top_monitor.sv */
// checker of the address mux and expanded_map_control_boundary at the top ports
`timescale 1ns/100ps
module dam_top_monitor
  import dam_pkg::*;
#(
  parameter int NUM_BANKS = 4
)(
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb slave side
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  input wire logic                  pready,
  // memory cycle and pins
  input wire logic [24:0]           cpu_addr,
  input wire logic [1:0]            bank_sel,
  input wire logic                  row_phase,
  input wire logic [10:0]           dram_mux_addr_out,
  // expanded memory state
  input wire logic [19:0]           upper_frame_base,
  input wire logic                  upper_map_en,
  input wire logic                  lower_map_en,
  input wire logic                  page_prog_en,
  input wire logic                  reserve_hit,
  input wire logic [PTR_W-1:0]      page_pointer
);
  // ----
  // shadow of the written registers
  // ----
  logic [15:0]                     ctl_q;
  logic [NUM_BANKS*BANK_CFG_W-1:0] bank_q;
  logic [4:0]                      cfg;
  logic                            done;
  logic                            pg;
  logic                            npn;
  logic                            np2;
  logic                            pacc;

  // configuration of the bank that steers the mux now
  assign done = psel & penable & pready;
  assign cfg  = bank_q[bank_sel*BANK_CFG_W +: BANK_CFG_W];
  assign pg   = cfg[BANK_PAGE_BIT];
  assign npn  = !pg && (cfg[3:2] == ILV_NONE || cfg[3:2] == ILV_RSVD);
  assign np2  = !pg && cfg[3:2] == ILV_2WAY;
  assign pacc = done && paddr == {IDX_PAGE_DATA, 2'b00};

  // follows completed writes only; matches the slave's copy except for the bits CTL_KEEP_MASK drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q  <= CTL_RST;
      bank_q <= '0;
    end else if (done && pwrite && paddr == {IDX_EMS_CTRL, 2'b00}) begin
      ctl_q <= pwdata[15:0];
    end else if (done && pwrite && paddr == {IDX_BANK_CFG, 2'b00}) begin
      bank_q <= pwdata[NUM_BANKS*BANK_CFG_W-1:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // decoded state lags the register by one edge
  property p_base;
    upper_frame_base == UPPER_BASE0 + UPPER_STEP * 20'($past(ctl_q[14:13]));
  endproperty
  a_base: assert property (p_base)
    else $error("upper frame base wrong");
  property p_prog;
    page_prog_en == ($past(ctl_q[11:10]) != FME_OFF);
  endproperty
  a_prog: assert property (p_prog)
    else $error("programming enable wrong");
  property p_upper;
    upper_map_en == $past(ctl_q[11]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper map enable wrong");
  property p_lower;
    lower_map_en == ($past(ctl_q[11:10]) == FME_ALL);
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower map enable wrong");
  property p_res;
    reserve_hit == ($past(ctl_q[7]) &&
      $past(cpu_addr[24:17]) > {1'b0, $past(ctl_q[6:0])});
  endproperty
  a_res: assert property (p_res)
    else $error("reserve decision wrong");
  property p_inc;
    pacc && ctl_q[CTL_INC_BIT] |=> page_pointer ==
      (($past(page_pointer) >= PTR_LAST) ? PTR_RST : $past(page_pointer) + 1);
  endproperty
  a_inc: assert property (p_inc)
    else $error("pointer did not advance");
  property p_hold;
    pacc && !ctl_q[CTL_INC_BIT] |=> $stable(page_pointer);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pointer moved without increment");

  // mux pins carry the mapping of the previous edge's inputs
  property p_pcol;
    !row_phase && pg |=> dram_mux_addr_out == $past(cpu_addr[11:1]);
  endproperty
  a_pcol: assert property (p_pcol)
    else $error("page column wrong");
  property p_ptop;
    row_phase && pg |=> dram_mux_addr_out[10:5] == $past({cpu_addr[22],
      cpu_addr[20], cpu_addr[18], cpu_addr[16], cpu_addr[15:14]});
  endproperty
  a_ptop: assert property (p_ptop)
    else $error("page row top wrong");
  property p_nrow;
    row_phase && npn |=> dram_mux_addr_out == $past(cpu_addr[11:1]);
  endproperty
  a_nrow: assert property (p_nrow)
    else $error("non-page row wrong");
  property p_n2row;
    row_phase && np2 |=>
      dram_mux_addr_out == $past({cpu_addr[11:2], cpu_addr[13]});
  endproperty
  a_n2row: assert property (p_n2row)
    else $error("two-way row wrong");
endmodule

bind dam_top dam_top_monitor #(.NUM_BANKS(NUM_BANKS)) dam_top_monitor_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .cpu_addr, .bank_sel, .row_phase, .dram_mux_addr_out, .upper_frame_base,
  .upper_map_en, .lower_map_en, .page_prog_en, .reserve_hit, .page_pointer);

/* File: bench/dam_simm_model.sv */
// memory module side: latches row then column off the mux pins
`timescale 1ns/100ps
module dam_simm_model (
  // clock
  input  wire logic        pclk,
  // strobe phase and address pins
  input  wire logic        row_phase,
  input  wire logic [10:0] dram_mux_addr_out,
  // addresses the module took
  output logic      [10:0] row_lat,
  output logic      [10:0] col_lat
);
  logic ras_phase;

  // pins lag the phase by one edge, so latch with the delayed phase
  always_ff @(posedge pclk) begin
    ras_phase <= row_phase;
    if (ras_phase)
      row_lat <= dram_mux_addr_out;
    else
      col_lat <= dram_mux_addr_out;
  end
endmodule

/* File: bench/tb_dam_top.sv */
// self-checking bench for the dram address mux and expanded_map_control_boundary
`timescale 1ns/100ps
module tb_dam_top
  import dam_pkg::*;
;
  localparam logic [19:0] CTL = {IDX_EMS_CTRL, 2'b00};
  localparam logic [19:0] BNK = {IDX_BANK_CFG, 2'b00};
  localparam logic [19:0] PTR = {IDX_POINTER, 2'b00};
  localparam logic [19:0] PGD = {IDX_PAGE_DATA, 2'b00};
  localparam logic [19:0] STS = {IDX_STATUS, 2'b00};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [19:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [24:0] cpu_addr;
  logic [1:0]  bank_sel;
  logic        row_phase;
  logic [10:0] dram_mux_addr_out;
  logic [19:0] upper_frame_base;
  logic        upper_map_en;
  logic        lower_map_en;
  logic        page_prog_en;
  logic        reserve_hit;
  logic [5:0]  page_pointer;
  logic [10:0] row_lat;
  logic [10:0] col_lat;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          comparisons = 0;

  dam_top #(.NUM_BANKS(4)) dam_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpu_addr, .bank_sel, .row_phase, .dram_mux_addr_out,
    .upper_frame_base, .upper_map_en, .lower_map_en, .page_prog_en,
    .reserve_hit, .page_pointer);
  dam_simm_model dam_simm_model_i (
    .pclk, .row_phase, .dram_mux_addr_out, .row_lat, .col_lat);

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  // ----
  // bus and compare helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; waits on pready, bounded against a hang
  task automatic apb(input logic w, logic [19:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  // page row: low bits swap cumulatively as the level rises
  function automatic logic [10:0] prow(input logic [24:0] a, int lv);
    logic [10:0] r;
    r = {a[22], a[20], a[18], a[16], a[15:9]};
    if (lv >= 1) r[0] = a[17];
    if (lv >= 2) r[1] = a[19];
    if (lv >= 3) r[2] = a[21];
    if (lv >= 4) r[3] = a[23];
    if (lv >= 5) r[4] = a[24];
    return r;
  endfunction

  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    end_of_test;
  end

  // ----
  // test sequence
  // ----
  initial begin
    logic [15:0] w;
    logic [24:0] a;
    logic [24:0] ba [3];
    logic [10:0] er;
    logic [10:0] ec;
    logic [1:0]  d;
    logic [1:0]  v;
    logic [1:0]  b;
    logic        p;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    cpu_addr = 25'h1ffffff;
    bank_sel = '0;
    row_phase = 0;
    presetn = 0;
    ba = '{25'h00fffff, 25'h0100000, 25'h1fe0000};
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, CTL, 0);
    chk("ctrl", 32'h0, rd);
    chk("ptr", 32'h0, 32'(page_pointer));
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = {1'b0, i[1:0], 1'b1, i[1:0], 2'b11, 8'h7f};
      apb(1, CTL, 32'(w));
      @(posedge pclk);
      #1;
      chk("base", 32'hc4000 + 32'h4000 * i, 32'(upper_frame_base));
      chk("en", 32'({i > 0, i > 1, i == 3}),
          32'({page_prog_en, upper_map_en, lower_map_en}));
      chk("hit", 32'h0, 32'(reserve_hit));
      apb(0, CTL, 0);
      chk("ctrl", 32'(w & CTL_KEEP_MASK), rd);
      apb(0, STS, 0);
      chk("status", 32'({1'b0, i > 0, i == 3, i > 1}), rd);
    end
    $display("frame test done");
    apb(1, CTL, 32'h0087);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      cpu_addr <= ba[k];
      @(posedge pclk);
      #1;
      chk("hit", 32'(k > 0), 32'(reserve_hit));
    end
    apb(1, CTL, 32'h0007);
    @(posedge pclk);
    #1;
    chk("hit", 32'h0, 32'(reserve_hit));
    $display("boundary test done");
    apb(1, CTL, 32'h0);
    apb(1, PTR, 32'h5);
    apb(1, PGD, 32'h1234);
    apb(1, CTL, 32'h8400);
    apb(1, PTR, 32'h5);
    apb(0, PGD, 0);
    chk("page5", 32'h0, rd);
    apb(1, PTR, 32'h26);
    apb(1, PGD, 32'h5a5a);
    apb(1, PGD, 32'ha5a5);
    #1;
    chk("wrap", 32'h0, 32'(page_pointer));
    apb(1, PTR, 32'h26);
    apb(0, PGD, 0);
    chk("page38", 32'h5a5a, rd);
    apb(0, PGD, 0);
    chk("page39", 32'ha5a5, rd);
    apb(1, CTL, 32'h0400);
    apb(1, PTR, 32'h3);
    apb(0, PGD, 0);
    #1;
    chk("ptr", 32'h3, 32'(page_pointer));
    apb(0, 20'h00010, 0);
    chk("slverr", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rd);
    $display("pointer test done");
    for (int i = 0; i < 32; i++) begin
      d = i[1:0];
      v = i[3:2];
      p = i[4];
      b = 2'(i + 1);
      apb(1, BNK, 32'({p, v, d}) << (5 * b));
      for (int k = 0; k < 2; k++) begin
        a = k ? 25'h15a5a5a : 25'h0a5a5a5;
        @(posedge pclk);
        cpu_addr  <= a;
        bank_sel  <= b;
        row_phase <= 1;
        @(posedge pclk);
        row_phase <= 0;
        repeat (2) @(posedge pclk);
        #1;
        er = prow(a, d + v % 3);
        ec = a[11:1];
        if (!p && (v == 0 || v == 3)) begin
          er = a[11:1];
          ec = prow(a, d + v % 3);
        end else if (!p && v == 1) begin
          er = {a[11:2], a[13]};
          ec = (d != 2) ? prow(a, d + v % 3) : {a[22], a[20], a[18], a[16],
               a[15], a[14], a[21], a[12], a[11], a[19], a[17]};
        end
        chk("row", 32'(er), 32'(row_lat));
        chk("col", 32'(ec), 32'(col_lat));
      end
    end
    $display("mux test done");
    end_of_test;
  end
endmodule
